// File: logic/cic_pkg.sv
package cic_pkg;

	localparam int          ADDR_W      = 13;
	localparam int          DATA_W      = 8;
	localparam int          PC_W        = 15;
	localparam int          NREG        = 9;
	localparam int          NPERIPH     = 64;
	localparam int          NSHADOW     = 8;

	localparam logic [12:0] CTRL_ADDR   = 13'h000b;
	localparam logic [12:0] FLAG_BASE   = 13'h070c;
	localparam logic [12:0] EN_BASE     = 13'h0716;
	localparam logic [12:0] STAT_ADDR   = 13'h0720;
	localparam logic [12:0] MASK_ADDR   = 13'h0721;
	localparam logic [12:0] SHADOW_BASE = 13'h1fe4;

	localparam int          GIE_BIT     = 7;
	localparam int          PERIPH_GROUP_IRQ_ENABLE_BIT    = 6;
	localparam int          EDGE_BIT    = 0;
	localparam logic [7:0]  CTRL_MASK   = 8'hc1;
	localparam logic [7:0]  CTRL_RESET  = 8'h01;

	localparam int          EXT_BIT     = 0;
	localparam int          CORE_EVT_LO = 4;
	localparam logic [7:0]  GRP0_MASK   = 8'h31;
	localparam logic [7:0]  FLAG_RESET  = 8'h00;
	localparam logic [7:0]  EN_RESET    = 8'h00;

	localparam int          STATUS_IDX  = 1;
	localparam logic [7:0]  STATUS_SAVE = 8'he7;
	localparam logic [7:0]  SHADOW_RST  = 8'h00;

	localparam logic [14:0] VECTOR_ADDR = 15'h0004;

	localparam int          ST_ENTRY    = 0;
	localparam int          ST_WAKE     = 1;
	localparam int          ST_EDGE     = 2;
	localparam logic [7:0]  STAT_MASK   = 8'h07;
	localparam logic [7:0]  STAT_RESET  = 8'h00;

	localparam logic [1:0]  PH_Q1       = 2'd0;
	localparam logic [1:0]  PH_Q4       = 2'd3;
	localparam logic [1:0]  PH_RESET    = 2'd0;

	typedef enum logic [1:0] {
		CIC_RUN,
		CIC_WAKE,
		CIC_ENTRY
	} cic_state_t;

endpackage

// File: logic/cic_edge_if.sv
`timescale 1ns/1ps
interface cic_edge_if;
	logic polarity;
	logic phase_ok;
	logic edge_set;

	modport ctrl (
		output polarity,
		output phase_ok,
		input  edge_set
	);

	modport det (
		input  polarity,
		input  phase_ok,
		output edge_set
	);
endinterface

// File: logic/cic_ext_edge.sv
`timescale 1ns/1ps
module cic_ext_edge (
	input  wire logic clk_i,      // core clock
	input  wire logic rst_i,      // synchronous reset, active high
	input  wire logic pin_i,      // external interrupt pin, asynchronous
	cic_edge_if.det   edge_if     // polarity in, flag set strobe out
);

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic pend_q;
	logic pend_d;
	logic edge_set_q;
	logic edge_set_d;

	wire  rise_w = sync2_q & ~prev_q;
	wire  fall_w = ~sync2_q & prev_q;
	// The pin may toggle at any time, so the edge is latched until the
	// phase window opens and only then turned into a flag set.
	wire  edge_w = edge_if.polarity ? rise_w : fall_w;

	assign pend_d     = (pend_q | edge_w) & ~edge_if.phase_ok;
	assign edge_set_d = (pend_q | edge_w) & edge_if.phase_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// The chain keeps following the pin in reset, so a pin that
			// idles high gives no false edge at release.
			sync1_q    <= pin_i;
			sync2_q    <= sync1_q;
			prev_q     <= sync2_q;
			pend_q     <= 1'b0;
			edge_set_q <= 1'b0;
		end else begin
			sync1_q    <= pin_i;
			sync2_q    <= sync1_q;
			prev_q     <= sync2_q;
			pend_q     <= pend_d;
			edge_set_q <= edge_set_d;
		end
	end

	assign edge_if.edge_set = edge_set_q;

endmodule // cic_ext_edge

// File: logic/cic_core_irq.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cic_core_irq (
	input  wire logic        clk_i,        // 20 MHz core clock
	input  wire logic        rst_i,        // synchronous reset, active high
	input  wire logic [12:0] addr_i,       // register address
	input  wire logic [7:0]  wdata_i,      // register write data
	input  wire logic        wr_i,         // write strobe
	input  wire logic        rd_i,         // read strobe
	output logic      [7:0]  rdata_o,      // read data, cycle after rd_i
	input  wire logic        ext_pin_i,    // external interrupt pin
	input  wire logic [1:0]  core_evt_i,   // group 0 event pulses
	input  wire logic [63:0] periph_evt_i, // peripheral event pulses
	input  wire logic        sleep_i,      // core is in sleep
	input  wire logic        return_from_service_i,     // return_from_service executes
	input  wire logic [63:0] ctx_live_i,   // live context bytes
	output logic      [63:0] ctx_shadow_o, // shadow context bytes
	output logic             restore_o,    // restore context from shadows
	output logic             pop_pc_o,     // pop return address
	output logic             flush_o,      // flush prefetched instruction
	output logic             push_pc_o,    // push program counter
	output logic             load_vector_o,// load PC with vector_o
	output logic      [14:0] vector_o,     // interrupt vector address
	output logic             wake_o,       // leave sleep
	output logic             q1_o,         // first quarter-phase marker
	output logic             gie_o,        // global_irq_enable state
	output logic             irq_o         // unmasked event status
);

	// Quarter-phase sequencer: one instruction cycle is four clocks.
	// Reset parks the counter in Q1, so requests are sampled at once.
	logic [1:0] phase_q;
	wire        q1_w = (phase_q == cic_pkg::PH_Q1);
	wire        q3_w = (phase_q == cic_pkg::PH_Q4 - 2'd1);
	wire        q4_w = (phase_q == cic_pkg::PH_Q4);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= cic_pkg::PH_RESET;
		end else begin
			phase_q <= phase_q + 2'd1;
		end
	end

	function automatic logic in_block(input logic [12:0] a,
	                                  input logic [12:0] base,
	                                  input int          n);
		logic [12:0] off;
		off = a - base;
		in_block = (a >= base) && (off < 13'(n));
	endfunction

	// Address decode.
	wire        ctrl_hit_w   = (addr_i == cic_pkg::CTRL_ADDR);
	wire        stat_hit_w   = (addr_i == cic_pkg::STAT_ADDR);
	wire        mask_hit_w   = (addr_i == cic_pkg::MASK_ADDR);
	wire        flag_hit_w   = in_block(addr_i, cic_pkg::FLAG_BASE,
	                                    cic_pkg::NREG);
	wire        en_hit_w     = in_block(addr_i, cic_pkg::EN_BASE,
	                                    cic_pkg::NREG);
	wire        shadow_hit_w = in_block(addr_i, cic_pkg::SHADOW_BASE,
	                                    cic_pkg::NSHADOW);
	wire [12:0] flag_off_w   = addr_i - cic_pkg::FLAG_BASE;
	wire [12:0] en_off_w     = addr_i - cic_pkg::EN_BASE;
	wire [12:0] sh_off_w     = addr_i - cic_pkg::SHADOW_BASE;
	wire [3:0]  flag_idx_w   = flag_off_w[3:0];
	wire [3:0]  en_idx_w     = en_off_w[3:0];
	wire [2:0]  sh_idx_w     = sh_off_w[2:0];

	// Control register: global enable, group enable, edge polarity.
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic       entry_w;
	wire        gie_w  = ctrl_q[cic_pkg::GIE_BIT];
	wire        periph_group_irq_enable_w = ctrl_q[cic_pkg::PERIPH_GROUP_IRQ_ENABLE_BIT];
	wire [7:0]  ctrl_wr_w = (wr_i && ctrl_hit_w) ?
	                        (wdata_i & cic_pkg::CTRL_MASK) : ctrl_q;

	// The return is applied last, so it beats a software write and an
	// entry in the same cycle.
	always_comb begin
		ctrl_d = ctrl_wr_w;
		if (entry_w) begin
			ctrl_d[cic_pkg::GIE_BIT] = 1'b0;
		end
		if (return_from_service_i) begin
			ctrl_d[cic_pkg::GIE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= cic_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// External pin edge detector.
	cic_edge_if edge_if ();
	assign edge_if.polarity = ctrl_q[cic_pkg::EDGE_BIT];
	// The detector registers its strobe, so opening the window one clock
	// early lands the flag set in the Q4 or Q1 clock itself.
	assign edge_if.phase_ok = q3_w | q4_w;

	cic_ext_edge u_ext_edge (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (ext_pin_i),
		.edge_if (edge_if)
	);

	// Flag and enable registers; index 0 is the core group, the rest
	// belong to the peripheral group.
	logic [7:0] flag_q [cic_pkg::NREG];
	logic [7:0] en_q   [cic_pkg::NREG];
	logic [cic_pkg::NREG-1:0] hit_w;

	genvar r;
	generate
		for (r = 0; r < cic_pkg::NREG; r++) begin : g_reg
			logic [7:0] set_w;
			logic [7:0] keep_w;
			logic [7:0] flag_wr_w;
			logic [7:0] en_wr_w;

			if (r == 0) begin : g_core
				always_comb begin
					set_w = 8'h00;
					set_w[cic_pkg::EXT_BIT] = edge_if.edge_set;
					set_w[cic_pkg::CORE_EVT_LO+:2] = core_evt_i;
				end
				assign keep_w = cic_pkg::GRP0_MASK;
			end else begin : g_periph
				assign set_w  = periph_evt_i[8*(r-1)+:8];
				assign keep_w = 8'hff;
			end

			assign flag_wr_w = (wr_i && flag_hit_w && flag_idx_w == 4'(r)) ?
			                   wdata_i : flag_q[r];
			assign en_wr_w   = (wr_i && en_hit_w && en_idx_w == 4'(r)) ?
			                   wdata_i : en_q[r];

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flag_q[r] <= cic_pkg::FLAG_RESET;
					en_q[r]   <= cic_pkg::EN_RESET;
				end else begin
					// A hardware set wins over a software clear in the same
					// cycle, and ignores every enable.
					flag_q[r] <= (flag_wr_w | set_w) & keep_w;
					en_q[r]   <= en_wr_w & keep_w;
				end
			end

			assign hit_w[r] = |(flag_q[r] & en_q[r]);
		end
	endgenerate

	// Request forming: group gating first, global gating last.
	wire periph_hit_w = periph_group_irq_enable_w & (|hit_w[cic_pkg::NREG-1:1]);
	wire pend_w       = hit_w[0] | periph_hit_w;
	wire req_w        = gie_w & pend_w;

	// Sequencer, advanced only in Q1 so a request is acted on at most
	// once per instruction cycle.
	cic_pkg::cic_state_t state_q;
	cic_pkg::cic_state_t state_d;
	logic                wake_w;
	logic                load_w;

	always_comb begin
		state_d = state_q;
		entry_w = 1'b0;
		wake_w  = 1'b0;
		load_w  = 1'b0;
		if (q1_w) begin
			unique case (state_q)
				cic_pkg::CIC_RUN: begin
					if (sleep_i) begin
						// Waking needs the source enables and, for the peripheral
						// group, the group enable; the global enable only picks the branch.
						if (pend_w) begin
							wake_w  = 1'b1;
							state_d = cic_pkg::CIC_WAKE;
						end
					end else if (req_w) begin
						entry_w = 1'b1;
						state_d = cic_pkg::CIC_ENTRY;
					end
				end
				cic_pkg::CIC_WAKE: begin
					// The instruction after sleep has now executed.
					if (req_w) begin
						entry_w = 1'b1;
						state_d = cic_pkg::CIC_ENTRY;
					end else begin
						state_d = cic_pkg::CIC_RUN;
					end
				end
				cic_pkg::CIC_ENTRY: begin
					// The flushed slot has been a forced no-op; the
					// vector fetch starts now, one instruction cycle after the
					// sample, so latency stays fixed for any instruction.
					load_w  = 1'b1;
					state_d = cic_pkg::CIC_RUN;
				end
				default: begin
					// The unused code falls back to normal running.
					state_d = cic_pkg::CIC_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= cic_pkg::CIC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Shadow context registers.
	// An entry save beats a software write in the same cycle.
	logic [7:0] shadow_q [cic_pkg::NSHADOW];

	genvar s;
	generate
		for (s = 0; s < cic_pkg::NSHADOW; s++) begin : g_shadow
			logic [7:0] save_mask_w;
			logic [7:0] saved_w;
			wire        sw_wr_w = wr_i && shadow_hit_w && sh_idx_w == 3'(s);

			if (s == cic_pkg::STATUS_IDX) begin : g_status
				assign save_mask_w = cic_pkg::STATUS_SAVE;
			end else begin : g_plain
				assign save_mask_w = 8'hff;
			end

			assign saved_w = (ctx_live_i[8*s+:8] & save_mask_w) |
			                 (shadow_q[s] & ~save_mask_w);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					shadow_q[s] <= cic_pkg::SHADOW_RST;
				end else if (entry_w) begin
					shadow_q[s] <= saved_w;
				end else if (sw_wr_w) begin
					shadow_q[s] <= wdata_i;
				end
			end

			assign ctx_shadow_o[8*s+:8] = shadow_q[s];
		end
	endgenerate

	// Event status with write-one-to-clear and a mask.
	// A set beats a clear in the same cycle, so no event is lost.
	logic [7:0] stat_q;
	logic [7:0] mask_q;
	logic [7:0] stat_set_w;
	wire  [7:0] stat_clr_w = (wr_i && stat_hit_w) ? wdata_i : 8'h00;
	wire  [7:0] stat_d;
	wire  [7:0] mask_d = (wr_i && mask_hit_w) ?
	                     (wdata_i & cic_pkg::STAT_MASK) : mask_q;

	always_comb begin
		stat_set_w = 8'h00;
		stat_set_w[cic_pkg::ST_ENTRY] = entry_w;
		stat_set_w[cic_pkg::ST_WAKE]  = wake_w;
		stat_set_w[cic_pkg::ST_EDGE]  = edge_if.edge_set;
	end

	assign stat_d = ((stat_q & ~stat_clr_w) | stat_set_w) &
	                cic_pkg::STAT_MASK;

	// Read mux. An index past the flag or enable array reads unknown,
	// but the hit selects never pick that branch then.
	wire [7:0] flag_rd_w = flag_q[flag_idx_w];
	wire [7:0] en_rd_w   = en_q[en_idx_w];
	wire [7:0] sh_rd_w   = shadow_q[sh_idx_w];
	wire [7:0] rd_mux_w  = ctrl_hit_w   ? ctrl_q    :
	                       flag_hit_w   ? flag_rd_w :
	                       en_hit_w     ? en_rd_w   :
	                       shadow_hit_w ? sh_rd_w   :
	                       stat_hit_w   ? stat_q    :
	                       mask_hit_w   ? mask_q    : 8'h00;

	// Outputs, all registered.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q        <= cic_pkg::STAT_RESET;
			mask_q        <= cic_pkg::STAT_RESET;
			irq_o         <= 1'b0;
			rdata_o       <= 8'h00;
			flush_o       <= 1'b0;
			push_pc_o     <= 1'b0;
			load_vector_o <= 1'b0;
			vector_o      <= cic_pkg::VECTOR_ADDR;
			restore_o     <= 1'b0;
			pop_pc_o      <= 1'b0;
			wake_o        <= 1'b0;
			q1_o          <= 1'b0;
			gie_o         <= 1'b0;
		end else begin
			stat_q        <= stat_d;
			mask_q        <= mask_d;
			irq_o         <= |(stat_d & mask_d);
			rdata_o       <= rd_i ? rd_mux_w : 8'h00;
			flush_o       <= entry_w;
			push_pc_o     <= entry_w;
			load_vector_o <= load_w;
			vector_o      <= cic_pkg::VECTOR_ADDR;
			restore_o     <= return_from_service_i;
			pop_pc_o      <= return_from_service_i;
			wake_o        <= wake_w;
			q1_o          <= (phase_q == cic_pkg::PH_Q4);
			gie_o         <= ctrl_d[cic_pkg::GIE_BIT];
		end
	end

endmodule // cic_core_irq

// File: bench/cic_core_irq_asserts.sv
`timescale 1ns/1ps
module cic_core_irq_asserts (
	input wire logic        clk_i,         // clock
	input wire logic        rst_i,         // reset
	input wire logic        rd_i,          // read strobe
	input wire logic [7:0]  rdata_o,       // read data
	input wire logic        return_from_service_i,      // return pulse
	input wire logic        restore_o,     // restore pulse
	input wire logic        pop_pc_o,      // pop pulse
	input wire logic        flush_o,       // flush pulse
	input wire logic        push_pc_o,     // push pulse
	input wire logic        load_vector_o, // vector load pulse
	input wire logic [14:0] vector_o,      // vector address
	input wire logic        wake_o,        // wake pulse
	input wire logic        q1_o,          // phase marker
	input wire logic        gie_o          // global enable
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	reset_clear_a: assert property ($fell(rst_i) |-> !gie_o && !flush_o)
		else $error("enable or entry seen after reset");
	entry_acts_a: assert property (flush_o |-> push_pc_o && !gie_o && $past(gie_o))
		else $error("entry without push or enable clear");
	entry_once_a: assert property (flush_o |=> !flush_o [*4])
		else $error("entry repeated");
	vector_wait_a: assert property (flush_o |-> ##4 load_vector_o)
		else $error("vector load late");
	vector_addr_a: assert property (load_vector_o |-> vector_o == 15'h0004)
		else $error("wrong vector");
	return_acts_a: assert property (return_from_service_i |=> restore_o && pop_pc_o && gie_o)
		else $error("return incomplete");
	q1_period_a: assert property (q1_o |=> !q1_o [*3] ##1 q1_o)
		else $error("phase period wrong");
	sleep_first_a: assert property (wake_o |=> !flush_o [*3])
		else $error("vector before next instruction");
	wake_vector_a: assert property (wake_o && gie_o |-> ##4 flush_o)
		else $error("no vector after wake");
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	cover property (flush_o);
	cover property (wake_o && !gie_o);
	cover property (return_from_service_i);
endmodule // cic_core_irq_asserts

bind cic_core_irq cic_core_irq_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .return_from_service_i(return_from_service_i),
	.restore_o(restore_o), .pop_pc_o(pop_pc_o), .flush_o(flush_o),
	.push_pc_o(push_pc_o), .load_vector_o(load_vector_o),
	.vector_o(vector_o), .wake_o(wake_o), .q1_o(q1_o), .gie_o(gie_o));

// File: bench/cic_core_model.sv
`timescale 1ns/1ps
module cic_core_model (
	input  wire logic        clk_i,       // clock
	input  wire logic        rst_i,       // reset
	input  wire logic [63:0] seed_i,      // context after reset
	input  wire logic        sleep_req_i, // enter sleep
	input  wire logic        ret_req_i,   // run return instruction
	input  wire logic        wake_i,      // leave sleep
	input  wire logic        flush_i,     // entry begins
	input  wire logic        restore_i,   // restore context
	input  wire logic [63:0] shadow_i,    // shadow bytes
	output logic             sleep_o,     // core asleep
	output logic             return_from_service_o,    // return pulse
	output logic      [63:0] ctx_o        // live context
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_o  <= 1'b0;
			return_from_service_o <= 1'b0;
			ctx_o    <= seed_i;
		end else begin
			return_from_service_o <= ret_req_i;
			if (wake_i)
				sleep_o <= 1'b0;
			else if (sleep_req_i)
				sleep_o <= 1'b1;
			// The routine clobbers every live register, so a lost save shows.
			if (restore_i)
				ctx_o <= shadow_i;
			else if (flush_i)
				ctx_o <= ~ctx_o;
		end
	end
endmodule // cic_core_model

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [63:0] CTX_M = 64'hffff_ffff_ffff_e7ff;
	logic        clk_i, rst_i, wr_i, rd_i, ext_pin_i, sleep_i, return_from_service_i;
	logic        flush_o, restore_o, wake_o, gie_o, irq_o;
	logic        sleep_req, ret_req;
	logic [12:0] addr_i;
	logic [7:0]  wdata_i, rdata_o;
	logic [1:0]  core_evt_i;
	logic [63:0] periph_evt_i, ctx, shadow, seed, saved, n, m;
	logic [63:0] n_entry = '0, n_wake = '0;
	logic [31:0] r;
	logic [5:0]  b;
	int          n_fail = 0, comparisons = 0;

	cic_core_irq dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ext_pin_i(ext_pin_i), .core_evt_i(core_evt_i),
		.periph_evt_i(periph_evt_i), .sleep_i(sleep_i), .return_from_service_i(return_from_service_i),
		.ctx_live_i(ctx), .ctx_shadow_o(shadow), .restore_o(restore_o),
		.pop_pc_o(), .flush_o(flush_o), .push_pc_o(), .load_vector_o(),
		.vector_o(), .wake_o(wake_o), .q1_o(), .gie_o(gie_o), .irq_o(irq_o));
	cic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .seed_i(seed),
		.sleep_req_i(sleep_req), .ret_req_i(ret_req), .wake_i(wake_o),
		.flush_i(flush_o), .restore_i(restore_o), .shadow_i(shadow),
		.sleep_o(sleep_i), .return_from_service_o(return_from_service_i), .ctx_o(ctx));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [12:0] preg(input logic [12:0] a, input logic [5:0] k);
		return a + 13'h0001 + {10'h000, k[5:3]};
	endfunction
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", {56'h0, e}, {56'h0, rdata_o});
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic evt(input logic [1:0] c, input logic [63:0] p);
		@(posedge clk_i);
		core_evt_i <= c;
		periph_evt_i <= p;
		@(posedge clk_i);
		core_evt_i <= 2'b00;
		periph_evt_i <= '0;
	endtask
	task automatic pulse_req(input logic sel);
		@(posedge clk_i);
		if (sel) ret_req <= 1'b1;
		else sleep_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		sleep_req <= 1'b0;
		wait_cyc(4);
	endtask
	task automatic irq_is(input logic e);
		wait_cyc(2);
		#1 chk("irq", {63'h0, e}, {63'h0, irq_o});
	endtask
	task automatic pin(input logic v, input logic [7:0] e);
		@(posedge clk_i);
		ext_pin_i <= v;
		wait_cyc(24);
		rd(cic_pkg::FLAG_BASE, e);
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk_i) begin
		if (flush_o === 1'b1) begin
			n_entry++;
			saved = ctx;
		end
		if (wake_o === 1'b1)
			n_wake++;
	end
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		wait_cyc(20000);
		n_fail++;
		give_verdict;
	end
	initial begin
		r = xs(32'h63b026ff);
		seed = {xs(r), r};
		{addr_i, wdata_i, wr_i, rd_i, ext_pin_i, sleep_req, ret_req} = '0;
		{core_evt_i, periph_evt_i} = '0;
		rst_i = 1'b1;
		wait_cyc(16);
		rst_i <= 1'b0;
		rd(cic_pkg::CTRL_ADDR, 8'h01);
		rd(cic_pkg::EN_BASE, 8'h00);
		rd(13'h0715, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = xs(r);
			b = r[5:0];
			evt(2'b01, 64'h1 << b);
			rd(cic_pkg::FLAG_BASE, 8'h10);
			rd(preg(cic_pkg::FLAG_BASE, b), 8'h01 << b[2:0]);
			if (i < 3) wr(preg(cic_pkg::FLAG_BASE, b), 8'h00);
		end
		wr(preg(cic_pkg::EN_BASE, b), 8'h01 << b[2:0]);
		wr(cic_pkg::CTRL_ADDR, 8'h81);
		n = n_entry;
		wait_cyc(24);
		chk("entry", n, n_entry);
		wr(cic_pkg::MASK_ADDR, 8'h01);
		wr(cic_pkg::CTRL_ADDR, 8'hc1);
		wait_cyc(24);
		chk("entry", n + 1, n_entry);
		rd(cic_pkg::CTRL_ADDR, 8'h41);
		rd(cic_pkg::SHADOW_BASE, saved[7:0]);
		rd(cic_pkg::SHADOW_BASE + 13'h0002, saved[23:16]);
		irq_is(1'b1);
		wr(cic_pkg::MASK_ADDR, 8'h00);
		irq_is(1'b0);
		wr(cic_pkg::STAT_ADDR, 8'h07);
		wr(cic_pkg::MASK_ADDR, 8'h01);
		irq_is(1'b0);
		wr(cic_pkg::SHADOW_BASE, 8'h5a);
		wr(preg(cic_pkg::FLAG_BASE, b), 8'h00);
		wr(cic_pkg::FLAG_BASE, 8'h00);
		pulse_req(1'b1);
		chk("ctx", {saved[63:8], 8'h5a} & CTX_M, ctx & CTX_M);
		chk("gie", 64'h1, {63'h0, gie_o});
		wait_cyc(24);
		chk("entry", n + 1, n_entry);
		wr(cic_pkg::EN_BASE, 8'h01);
		pin(1'b1, 8'h01);
		chk("entry", n + 2, n_entry);
		wr(cic_pkg::FLAG_BASE, 8'h00);
		pulse_req(1'b1);
		wr(cic_pkg::CTRL_ADDR, 8'h00);
		pin(1'b0, 8'h01);
		wr(cic_pkg::FLAG_BASE, 8'h00);
		pin(1'b1, 8'h00);
		wr(cic_pkg::EN_BASE, 8'h20);
		for (int g = 0; g < 2; g++) begin
			n = n_entry;
			m = n_wake;
			wr(cic_pkg::CTRL_ADDR, g ? 8'h80 : 8'h00);
			pulse_req(1'b0);
			evt(2'b10, 64'h0);
			wait_cyc(24);
			chk("wake", m + 1, n_wake);
			chk("entry", n + g, n_entry);
			wr(cic_pkg::FLAG_BASE, 8'h00);
		end
		pulse_req(1'b1);
		rst_i <= 1'b1;
		wait_cyc(2);
		rst_i <= 1'b0;
		rd(cic_pkg::CTRL_ADDR, 8'h01);
		rd(preg(cic_pkg::EN_BASE, b), 8'h00);
		wait_cyc(8);
		rd(cic_pkg::FLAG_BASE, 8'h00);
		give_verdict;
	end
endmodule // tb
